// [potslv_pkg.sv]
// Constants, types and state codes of the two-wire potentiometer slave.
// Assumes a single core clock of 25 MHz and bus pins sampled through synchronisers.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package potslv_pkg;

	// ------------------------------------------------------------------------
	// Bus identity and timing
	// ------------------------------------------------------------------------
	localparam logic [3:0] POTSLV_TYPE_CODE     = 4'h5; // Arbitrary value
	localparam int         POTSLV_CLK_HZ        = 25_000_000;
	localparam int         POTSLV_NVW_MS        = 20;
	localparam int         POTSLV_NVW_CYC       = POTSLV_CLK_HZ / 1000 * POTSLV_NVW_MS;
	localparam int         POTSLV_PWRUP_CYC     = 16;

	// ------------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------------
	localparam logic [7:0] POTSLV_ADR_WIPER0    = 8'h00;
	localparam logic [7:0] POTSLV_ADR_WIPER1    = 8'h01;
	localparam logic [7:0] POTSLV_ADR_GP_LO     = 8'h02;
	localparam logic [7:0] POTSLV_ADR_GP_HI     = 8'h06;
	localparam logic [7:0] POTSLV_ADR_CTRL      = 8'h08;
	localparam int         POTSLV_CTRL_VSEL_BIT = 7;
	localparam int         POTSLV_CTRL_SHDN_BIT = 6;
	localparam int         POTSLV_CTRL_BUSY_BIT = 5;
	localparam logic [7:0] POTSLV_WIPER_RST     = 8'h40;
	localparam logic [7:0] POTSLV_CTRL_RST      = 8'h40;
	localparam logic [7:0] POTSLV_NV_RST        = 8'h40;

	// ------------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} potslv_wr_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} potslv_pins_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b00_0001,
		ST_RECV = 6'b00_0010,
		ST_RACK = 6'b00_0100,
		ST_SEND = 6'b00_1000,
		ST_MACK = 6'b01_0000,
		ST_DONE = 6'b10_0000
	} potslv_state_t;

endpackage

// [potslv_fifo.sv]
// Small synchronous FIFO carrying received write words to the register file.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module potslv_fifo
	import potslv_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wp_ff;
	logic [AW-1:0]    nxt_wp;
	logic [AW-1:0]    rp_ff;
	logic [AW-1:0]    nxt_rp;
	logic [AW:0]      cnt_ff;
	logic [AW:0]      nxt_cnt;
	logic             push;
	logic             pop;

	// ------------------------------------------------------------------------
	// Pointers
	// ------------------------------------------------------------------------
	assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rp_ff];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		nxt_wp  = push ? AW'(wp_ff + 1'b1) : wp_ff;
		nxt_rp  = pop ? AW'(rp_ff + 1'b1) : rp_ff;
		nxt_cnt = cnt_ff;
		if (push && !pop) begin
			nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
		end else if (pop && !push) begin
			nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			wp_ff  <= nxt_wp;
			rp_ff  <= nxt_rp;
			cnt_ff <= nxt_cnt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_ff[wp_ff] <= in_data;
		end
	end
endmodule

// [potslv_top.sv]
// Two-wire slave interface of the dual potentiometer with its register file.
// Assumes bus pins from outside the clock domain and an external pull-up on data.
`timescale 1ns/1ps
module potslv_top
	import potslv_pkg::*;
#(
	parameter int NVW_CYC   = POTSLV_NVW_CYC,
	parameter int PWRUP_CYC = POTSLV_PWRUP_CYC,
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Serial bus pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	// Address straps
	input  wire logic       addr_strap_bit2,
	input  wire logic       addr_strap_bit1,
	input  wire logic       addr_strap_bit0,
	// Potentiometer controls
	output logic [6:0]      wiper0_pos,
	output logic [6:0]      wiper1_pos,
	output logic            shutdown_bit,
	output logic            nv_write_busy_flag,
	output logic            volatile_select_bit
);
	// ------------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------------
	potslv_pins_t s1_ff, s2_ff, s3_ff;
	logic [2:0]   strap_s1_ff;
	logic [2:0]   strap_ff;
	logic         scl_rise, scl_fall, start_det, stop_det;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s1_ff <= '1;
			s2_ff <= '1;
			s3_ff <= '1;
		end else begin
			s1_ff <= '{scl: scl_in, sda: sda_in};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	always_ff @(posedge core_clk) begin
		strap_s1_ff <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
		strap_ff    <= strap_s1_ff;
	end

	assign scl_rise  = s2_ff.scl && !s3_ff.scl;
	assign scl_fall  = !s2_ff.scl && s3_ff.scl;
	assign start_det = s2_ff.scl && s3_ff.scl && !s2_ff.sda && s3_ff.sda;
	assign stop_det  = s2_ff.scl && s3_ff.scl && s2_ff.sda && !s3_ff.sda;

	// ------------------------------------------------------------------------
	// Register file state
	// ------------------------------------------------------------------------
	logic [7:0]  nv_ff [9];
	logic [7:0]  wiper_ff [2];
	logic [7:0]  ctrl_ff;
	logic [31:0] busy_cnt_ff;
	logic        nv_pend_ff;
	logic [$clog2(PWRUP_CYC+1)-1:0] pwr_cnt_ff;
	logic        pwr_ok;

	assign pwr_ok = (pwr_cnt_ff == '0);
	assign nv_write_busy_flag  = (busy_cnt_ff != '0);
	assign volatile_select_bit = ctrl_ff[POTSLV_CTRL_VSEL_BIT];
	assign shutdown_bit        = ctrl_ff[POTSLV_CTRL_SHDN_BIT];
	assign wiper0_pos          = wiper_ff[0][6:0];
	assign wiper1_pos          = wiper_ff[1][6:0];

	// ------------------------------------------------------------------------
	// Serial engine
	// ------------------------------------------------------------------------
	potslv_state_t st_ff, nxt_st;
	logic [7:0] sh_ff, nxt_sh;
	logic [3:0] bit_ff, nxt_bit;
	logic [1:0] byte_ff, nxt_byte;
	logic       rd_ff, nxt_rd;
	logic [7:0] ptr_ff, nxt_ptr;
	logic       drv_ff, nxt_drv;
	logic       wr_valid;
	logic       wr_ready;
	potslv_wr_t wr_word;
	logic [7:0] rd_data;

	// Read mux follows the volatile-select bit for the two wiper addresses only
	always_comb begin
		rd_data = 8'h00;
		if (ptr_ff <= POTSLV_ADR_WIPER1) begin
			rd_data = volatile_select_bit ? wiper_ff[ptr_ff[0]]
			                             : nv_ff[ptr_ff[3:0]];
		end else if (ptr_ff == POTSLV_ADR_CTRL) begin
			rd_data = {ctrl_ff[7:6], nv_write_busy_flag, 5'h00};
		end else if (ptr_ff <= POTSLV_ADR_GP_HI) begin
			rd_data = nv_ff[ptr_ff[3:0]];
		end
	end

	function automatic logic [7:0] ptr_inc(input logic [7:0] p);
		ptr_inc = (p >= POTSLV_ADR_CTRL) ? 8'h00 : 8'(p + 8'h01);
	endfunction

	always_comb begin
		nxt_st   = st_ff;
		nxt_sh   = sh_ff;
		nxt_bit  = bit_ff;
		nxt_byte = byte_ff;
		nxt_rd   = rd_ff;
		nxt_ptr  = ptr_ff;
		nxt_drv  = drv_ff;
		wr_valid = 1'b0;
		wr_word  = '{addr: ptr_ff, data: sh_ff};
		if (stop_det) begin
			nxt_st  = ST_IDLE;
			nxt_drv = 1'b0;
		end else if (start_det && pwr_ok) begin
			nxt_st   = ST_RECV;
			nxt_bit  = 4'h0;
			nxt_byte = 2'd0;
			nxt_drv  = 1'b0;
		end else begin
			case (st_ff)
				ST_IDLE, ST_DONE: begin
					nxt_drv = 1'b0;
				end
				ST_RECV: begin
					if (scl_rise) begin
						nxt_sh  = {sh_ff[6:0], s2_ff.sda};
						nxt_bit = 4'(bit_ff + 4'h1);
					end else if (scl_fall && bit_ff == 4'd8) begin
						nxt_bit = 4'h0;
						nxt_st  = ST_RACK;
						nxt_drv = 1'b1;
						if (byte_ff == 2'd0) begin
							if (sh_ff[7:1] != {POTSLV_TYPE_CODE, strap_ff}) begin
								nxt_st  = ST_DONE;
								nxt_drv = 1'b0;
							end else begin
								nxt_rd = sh_ff[0];
							end
						end else if (byte_ff == 2'd1) begin
							nxt_ptr = sh_ff;
						end else if (!wr_ready) begin
							nxt_drv = 1'b0;
						end else begin
							wr_valid = 1'b1;
							nxt_ptr  = ptr_inc(ptr_ff);
						end
					end
				end
				ST_RACK: begin
					if (scl_fall) begin
						nxt_drv = 1'b0;
						if (byte_ff != 2'd2) begin
							nxt_byte = 2'(byte_ff + 2'd1);
						end
						if (byte_ff == 2'd0 && rd_ff) begin
							nxt_st  = ST_SEND;
							nxt_sh  = rd_data;
							nxt_drv = !rd_data[7];
							nxt_bit = 4'h1;
						end else begin
							nxt_st = ST_RECV;
						end
					end
				end
				ST_SEND: begin
					if (scl_fall) begin
						if (bit_ff == 4'd8) begin
							nxt_drv = 1'b0;
							nxt_st  = ST_MACK;
							nxt_ptr = ptr_inc(ptr_ff);
						end else begin
							nxt_sh  = {sh_ff[6:0], 1'b0};
							nxt_drv = !sh_ff[6];
							nxt_bit = 4'(bit_ff + 4'h1);
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						nxt_rd = !s2_ff.sda;
					end else if (scl_fall) begin
						if (rd_ff) begin
							nxt_st  = ST_SEND;
							nxt_sh  = rd_data;
							nxt_drv = !rd_data[7];
							nxt_bit = 4'h1;
						end else begin
							nxt_st = ST_DONE;
						end
					end
				end
				default: begin
					nxt_st  = ST_IDLE;
					nxt_drv = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_ff   <= ST_IDLE;
			sh_ff   <= 8'h00;
			bit_ff  <= 4'h0;
			byte_ff <= 2'd0;
			rd_ff   <= 1'b0;
			ptr_ff  <= 8'h00;
			drv_ff  <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			sh_ff   <= nxt_sh;
			bit_ff  <= nxt_bit;
			byte_ff <= nxt_byte;
			rd_ff   <= nxt_rd;
			ptr_ff  <= nxt_ptr;
			drv_ff  <= nxt_drv;
		end
	end

	// Open-drain: only ever pulls low, clock is never driven
	assign sda_out  = 1'b0;
	assign sda_oe_n = !drv_ff;

	// ------------------------------------------------------------------------
	// Write buffer
	// ------------------------------------------------------------------------
	logic       q_valid;
	logic       q_ready;
	potslv_wr_t q_word;

	potslv_fifo #(
		.WIDTH ($bits(potslv_wr_t)),
		.DEPTH (FIFO_DEPTH)
	) potslv_fifo_i (
		.core_clk  (core_clk),
		.rst       (rst),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   (wr_word),
		.out_valid (q_valid),
		.out_ready (q_ready),
		.out_data  (q_word)
	);

	// Drained one word per cycle; stalls while the engine is in ST_SEND
	assign q_ready = (st_ff != ST_SEND);

	// ------------------------------------------------------------------------
	// Register file update
	// ------------------------------------------------------------------------
	logic        apply;
	logic        lock;
	logic        nxt_pend;
	logic [31:0] nxt_busy;

	assign apply = q_valid && q_ready;
	assign lock  = nv_write_busy_flag;

	always_comb begin
		nxt_pend = nv_pend_ff;
		nxt_busy = busy_cnt_ff;
		if (busy_cnt_ff != '0) begin
			nxt_busy = busy_cnt_ff - 32'd1;
		end
		if (apply && !lock && q_word.addr <= POTSLV_ADR_GP_HI
		    && !(q_word.addr <= POTSLV_ADR_WIPER1 && volatile_select_bit)) begin
			nxt_pend = 1'b1;
		end
		if (stop_det && nv_pend_ff) begin
			nxt_pend = 1'b0;
			nxt_busy = 32'(NVW_CYC);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			nv_pend_ff  <= 1'b0;
			busy_cnt_ff <= '0;
			pwr_cnt_ff  <= ($clog2(PWRUP_CYC+1))'(PWRUP_CYC);
			ctrl_ff     <= POTSLV_CTRL_RST;
			wiper_ff[0] <= POTSLV_WIPER_RST;
			wiper_ff[1] <= POTSLV_WIPER_RST;
			for (int i = 0; i < 9; i++) begin
				nv_ff[i] <= POTSLV_NV_RST;
			end
		end else begin
			nv_pend_ff  <= nxt_pend;
			busy_cnt_ff <= nxt_busy;
			if (!pwr_ok) begin
				pwr_cnt_ff  <= pwr_cnt_ff - 1'b1;
				wiper_ff[0] <= nv_ff[0];
				wiper_ff[1] <= nv_ff[1];
			end
			if (apply && !lock) begin
				if (q_word.addr == POTSLV_ADR_CTRL) begin
					ctrl_ff <= {q_word.data[7:6], 6'h00};
				end else if (q_word.addr <= POTSLV_ADR_WIPER1) begin
					wiper_ff[q_word.addr[0]] <= q_word.data;
					if (!volatile_select_bit) begin
						nv_ff[q_word.addr[3:0]] <= q_word.data;
					end
				end else if (q_word.addr <= POTSLV_ADR_GP_HI) begin
					nv_ff[q_word.addr[3:0]] <= q_word.data;
				end
			end
		end
	end
endmodule

// [potslv_assertions.sv]
// Pin-level checks of the potentiometer two-wire slave.
// Assumes it is bound to potslv_top and sees one core clock domain.
`timescale 1ns/1ps
module potslv_assertions
	import potslv_pkg::*;
#(
	parameter int NVW_CYC   = 50,
	parameter int PWRUP_CYC = 16
) (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// Bus pins
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe_n,
	// Controls
	input wire logic [6:0] wiper0_pos,
	input wire logic [6:0] wiper1_pos,
	input wire logic       shutdown_bit,
	input wire logic       nv_write_busy_flag,
	input wire logic       volatile_select_bit
);
	// ------------------------------------------------------------------------
	// Cycle counters
	// ------------------------------------------------------------------------
	logic [31:0] pu_ff;
	logic [31:0] nxt_pu;
	logic [31:0] bz_ff;
	logic [31:0] nxt_bz;

	always_comb begin
		nxt_pu = (pu_ff < PWRUP_CYC) ? pu_ff + 32'h1 : pu_ff;
		nxt_bz = nv_write_busy_flag ? bz_ff + 32'h1 : 32'h0;
	end

	always_ff @(posedge core_clk) begin
		pu_ff <= rst ? 32'h0 : nxt_pu;
		bz_ff <= rst ? 32'h0 : nxt_bz;
	end

	// ------------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_early_start;
		(pu_ff < PWRUP_CYC) && scl_in && $fell(sda_in);
	endsequence

	sequence s_clk_pulse;
		##[1:12] $rose(scl_in) ##[1:12] $fell(scl_in);
	endsequence

	chk_reset_state: assert property ($fell(rst) |-> sda_oe_n && shutdown_bit
		&& !nv_write_busy_flag && !volatile_select_bit && wiper0_pos == 7'h40)
		else $error("state after reset wrong");
	chk_open_drain: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	chk_pwrup_quiet: assert property (s_early_start |=> sda_oe_n throughout (1'b1 ##90 1'b1))
		else $error("start during power-up answered");
	chk_pull_clk_low: assert property ($fell(sda_oe_n) |-> !scl_in)
		else $error("data pulled while clock high");
	chk_release_clk_low: assert property ($rose(sda_oe_n) |-> !scl_in)
		else $error("data released while clock high");
	chk_bit_holds: assert property ($fell(sda_oe_n) |-> !sda_oe_n throughout s_clk_pulse)
		else $error("driven bit not held over clock pulse");
	chk_busy_at_stop: assert property ($rose(nv_write_busy_flag) |-> scl_in && sda_in)
		else $error("busy began outside stop");
	chk_busy_len: assert property ($fell(nv_write_busy_flag) |-> bz_ff == NVW_CYC)
		else $error("busy length wrong");
	chk_busy_lock: assert property (nv_write_busy_flag |=> $stable(volatile_select_bit)
		&& $stable(wiper0_pos) && $stable(wiper1_pos))
		else $error("register changed while busy");
endmodule

bind potslv_top potslv_assertions #(.NVW_CYC(NVW_CYC), .PWRUP_CYC(PWRUP_CYC)) potslv_assertions_i (
	.core_clk(core_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .wiper0_pos(wiper0_pos), .wiper1_pos(wiper1_pos),
	.shutdown_bit(shutdown_bit), .nv_write_busy_flag(nv_write_busy_flag),
	.volatile_select_bit(volatile_select_bit));

// [potslv_host.sv]
// Behavioural two-wire bus master with a 320 ns clock slot.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
module potslv_host (
	// Bus lines
	output logic     scl,
	output logic     sda_rel,
	input wire logic sda_bus
);
	logic fr;

	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
		fr = 1'b0;
	end

	// One clock slot, data changed only while clock low
	task automatic slot(input logic v, output logic s);
		scl = 1'b0;
		#60 sda_rel = v;
		#140 scl = 1'b1;
		#60 s = sda_bus;
		#60;
	endtask

	task automatic start();
		if (fr) begin
			scl = 1'b0;
			#100 sda_rel = 1'b1;
			#100 scl = 1'b1;
		end
		#100 sda_rel = 1'b0;
		#100 fr = 1'b1;
	endtask

	task automatic stop();
		scl = 1'b0;
		#100 sda_rel = 1'b0;
		#100 scl = 1'b1;
		#100 sda_rel = 1'b1;
		#200 fr = 1'b0;
	endtask

	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) slot(b[i], s);
		slot(1'b1, s);
		ack = ~s;
	endtask

	task automatic rbyte(input logic ack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			slot(1'b1, s);
			b[i] = s;
		end
		slot(~ack, s);
	endtask
endmodule

// [potslv_top_bench.sv]
// Self-checking bench of the potentiometer slave driven by a master model.
// Assumes the package, design, checker and master model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("unexpected %s: expected %0h seen %0h", nm, e, g); \
	end \
end
module potslv_top_bench
	import potslv_pkg::*;
;
	localparam int NVW = 2000;
	logic       core_clk = 1'b0;
	logic       rst = 1'b1;
	logic [2:0] strap = 3'h0;
	logic       scl;
	logic       sda_rel;
	logic       sda_out;
	logic       sda_oe_n;
	logic       shdn;
	logic       busy;
	logic       vsel;
	logic [6:0] w0;
	logic [6:0] w1;
	logic       ack;
	logic [7:0] q [3];
	logic [7:0] a;
	logic [7:0] v;
	logic [7:0] bad;
	logic [6:0] e0;
	int         n_errors = 0;
	int         cmp_count = 0;
	int         cyc = 0;
	wire        sda_bus = sda_rel & (sda_oe_n | sda_out);

	always #20 core_clk = ~core_clk;

	potslv_top #(.NVW_CYC(NVW), .PWRUP_CYC(16), .FIFO_DEPTH(4)) potslv_top_i (
		.core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .addr_strap_bit2(strap[2]), .addr_strap_bit1(strap[1]),
		.addr_strap_bit0(strap[0]), .wiper0_pos(w0), .wiper1_pos(w1), .shutdown_bit(shdn),
		.nv_write_busy_flag(busy), .volatile_select_bit(vsel));

	potslv_host potslv_host_i (.scl(scl), .sda_rel(sda_rel), .sda_bus(sda_bus));

	function automatic logic [7:0] id_byte(input logic rw);
		return {POTSLV_TYPE_CODE, strap, rw};
	endfunction

	function automatic logic [7:0] ctrl_val(input logic vl, input logic sd, input logic bz);
		return {vl, sd, bz, 5'h00};
	endfunction

	task automatic wr(input logic [7:0] ad, input logic [7:0] d0, input logic [7:0] d1, input int n);
		potslv_host_i.start();
		potslv_host_i.wbyte(id_byte(1'b0), ack);
		`CHK("id ack", 1'b1, ack)
		potslv_host_i.wbyte(ad, ack);
		`CHK("addr ack", 1'b1, ack)
		for (int i = 0; i < n; i++) begin
			potslv_host_i.wbyte(i ? d1 : d0, ack);
			`CHK("data ack", 1'b1, ack)
		end
		potslv_host_i.stop();
	endtask

	task automatic rd(input logic [7:0] ad, input int n);
		potslv_host_i.start();
		potslv_host_i.wbyte(id_byte(1'b0), ack);
		potslv_host_i.wbyte(ad, ack);
		potslv_host_i.start();
		potslv_host_i.wbyte(id_byte(1'b1), ack);
		`CHK("read id ack", 1'b1, ack)
		for (int i = 0; i < n; i++) potslv_host_i.rbyte(i < n - 1, q[i]);
		potslv_host_i.stop();
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			wrap_up();
		end
	end

	initial begin
		void'($urandom(53498));
		repeat (3) @(posedge core_clk);
		#2;
		strap = 3'($urandom);
		rst = 1'b0;
		`CHK("reset state", {7'h40, 7'h40, 4'h9}, {w0, w1, shdn, busy, vsel, sda_oe_n})
		potslv_host_i.start();
		potslv_host_i.wbyte(id_byte(1'b0), ack);
		`CHK("early start ack", 1'b0, ack)
		potslv_host_i.stop();
		$display("test power-up done");
		for (int k = 0; k < 2; k++) begin
			bad = k ? {POTSLV_TYPE_CODE, ~strap, 1'b0} : {~POTSLV_TYPE_CODE, strap, 1'b0};
			potslv_host_i.start();
			potslv_host_i.wbyte(bad, ack);
			`CHK("bad id ack", 1'b0, ack)
			potslv_host_i.stop();
		end
		$display("test bad id done");
		e0 = 7'($urandom);
		wr(8'h08, 8'h80, {1'b0, e0}, 2);
		`CHK("ctrl after write", 3'h4, {vsel, shdn, busy})
		`CHK("wrapped write", e0, w0)
		rd(8'h07, 3);
		`CHK("reserved read", 8'h00, q[0])
		`CHK("ctrl read", ctrl_val(1'b1, 1'b0, 1'b0), q[1])
		`CHK("wrapped read", {1'b0, e0}, q[2])
		$display("test wrap done");
		repeat (4) begin
			a = 8'($urandom % 2);
			v = 8'($urandom % 128);
			if (a == 8'h00) e0 = v[6:0];
			wr(a, v, 8'h00, 1);
			`CHK("wiper pos", v[6:0], a[0] ? w1 : w0)
			rd(a, 1);
			`CHK("wiper read", v, q[0])
		end
		`CHK("no nv cycle", 1'b0, busy)
		$display("test random wipers done");
		wr(8'h08, 8'h40, 8'h00, 1);
		v = 8'($urandom % 128);
		wr(8'h01, v, 8'h00, 1);
		`CHK("store copy", v[6:0], w1)
		`CHK("busy after stop", 1'b1, busy)
		wr(8'h00, {1'b0, ~e0}, 8'h00, 1);
		`CHK("locked wiper", e0, w0)
		rd(8'h08, 1);
		`CHK("busy read", ctrl_val(1'b0, 1'b1, 1'b1), q[0])
		for (int i = 0; i < NVW + 100 && busy !== 1'b0; i++) @(posedge core_clk);
		#2;
		`CHK("busy cleared", 1'b0, busy)
		rd(8'h01, 1);
		`CHK("store read", v, q[0])
		$display("test nv write done");
		wrap_up();
	end
endmodule
